// File: dv/dmo_ctl_model.sv
`timescale 1ns/1ps
// controller stand-in: free-running memory clock, pins change on its fall
module dmo_ctl_model (
  output logic ck_pin,
  output logic cke_pin,
  output logic cs_n_pin,
  output logic ras_n_pin,
  output logic cas_n_pin,
  output logic we_n_pin,
  output logic [2:0] ba_pin,
  output logic [13:0] addr_pin,
  output logic odt_pin
);
  // idle levels before the first command
  initial begin
    ck_pin = 1'b0;
    cke_pin = 1'b1;
    {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 4'hf;
    ba_pin = 3'h0;
    addr_pin = 14'h0;
    odt_pin = 1'b0;
  end
  // memory clock keeps running between commands
  always #40 ck_pin = ~ck_pin;
  // one command per rise; gap zero lets the next one follow on the next rise
  task cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic ke, input int gap);
    if (c == 4'h0 && odt_pin) begin // termination off well before a mode write
      odt_pin = 1'b0;
      repeat (3) @(negedge ck_pin);
    end
    @(negedge ck_pin);
    cke_pin = ke;
    {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = c;
    ba_pin = b;
    addr_pin = a;
    @(posedge ck_pin);
    repeat (gap) begin // spacing after any command: gap clocks deselected
      @(negedge ck_pin);
      {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 4'hf;
      addr_pin = ~a; // deselected bus never shows the stale value
    end
  endtask : cmd
  // termination pin level
  task term(input logic v);
    @(negedge ck_pin);
    odt_pin = v;
  endtask : term
endmodule : dmo_ctl_model

// File: dv/dmo_top_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module dmo_top_test;
  localparam logic [1:0] E1 = dmo_pkg::SEL_EMR1;
  localparam logic [1:0] E2 = dmo_pkg::SEL_EMR2;
  localparam logic [1:0] E3 = dmo_pkg::SEL_EMR3;
  localparam logic [1:0] M0 = dmo_pkg::SEL_MR;
  logic clk_sys = 1'b0;
  logic nrst, read_drive, code_valid, code_ready;
  logic [3:0] code_word, pullup_step, pulldown_step, got_col;
  logic ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, odt_pin;
  logic [2:0] ba_pin, additive_latency, act_bank, col_bank;
  logic [13:0] addr_pin, emr2, emr3, act_row;
  logic out_oe_n, dq_level, dqs_level, dqs_n_level, code_reserved, dll_enabled, dll_locked;
  logic self_refresh, odt_on, burst_len4, act_valid, col_valid, col_write;
  logic [1:0] rtt_sel;
  logic [7:0] bank_open;
  logic [16:0] got_act;
  int err_total, num_checks, n_rsv, n_rise, col_rise, up, dn, r0;
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  dmo_ctl_model ctl (.ck_pin, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin,
    .ba_pin, .addr_pin, .odt_pin);
  dmo_top dut (.clk_sys, .nrst, .ck_pin, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin, .ba_pin,
    .addr_pin, .odt_pin, .code_valid, .code_word, .code_ready, .read_drive, .out_oe_n, .dq_level, .dqs_level,
    .dqs_n_level, .pullup_step, .pulldown_step, .code_reserved, .dll_enabled, .dll_locked, .self_refresh,
    .odt_on, .rtt_sel, .additive_latency, .burst_len4, .emr2, .emr3, .act_valid, .act_bank, .act_row,
    .col_valid, .col_write, .col_bank, .bank_open);
  // one-cycle pulses are caught here, so no check can miss them
  always @(posedge ck_pin) n_rise++;
  always @(posedge clk_sys) begin
    if (act_valid === 1'b1) got_act <= {act_bank, act_row};
    if (col_valid === 1'b1) begin
      got_col <= {col_write, col_bank};
      col_rise <= n_rise;
    end
    if (code_reserved === 1'b1) n_rsv <= n_rsv + 1;
  end
  task give_verdict;
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task ck(input int n);
    repeat (n) @(negedge ck_pin);
  endtask : ck
  task emr(input logic [1:0] s, input logic [13:0] a);
    ctl.cmd(4'h0, {1'b0, s}, a, 1'b1, 2);
  endtask : emr
  // offer one word; returns after the taking edge with valid still up
  task push(input logic [3:0] w);
    int n;
    n = 0;
    code_valid = 1'b1;
    code_word = w;
    while (code_ready !== 1'b1 && n < 64) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 64) begin
      err_total++;
      give_verdict();
    end
    @(negedge clk_sys);
  endtask : push
  task t_reset;
    `CHK("oe_n", 1'b1, out_oe_n)
    `CHK("steps", 8'h88, {pullup_step, pulldown_step})
  endtask : t_reset
  // upper registers, dll on, then dll reset with burst of four
  task t_init;
    emr(E2, 14'h0080); // only bit 7 set
    `CHK("emr2", 14'h0080, emr2)
    emr(E3, 14'h0000);
    `CHK("emr3", 14'h0000, emr3)
    emr(E1, 14'h0000);
    `CHK("dll_on", 1'b1, dll_enabled)
    emr(M0, 14'h0102);
    `CHK("bl4", 1'b1, burst_len4)
    ck(190);
    `CHK("lock_early", 1'b0, dll_locked)
    ck(20);
    `CHK("lock", 1'b1, dll_locked)
  endtask : t_init
  // termination follows the pin except in self-refresh
  task t_odt_sr;
    emr(E1, 14'h0014);
    `CHK("al", 3'h2, additive_latency)
    `CHK("rtt", 2'h1, rtt_sel)
    ctl.term(1'b1);
    ck(2);
    `CHK("odt", 1'b1, odt_on)
    ctl.cmd(4'h1, 3'h0, 14'h0000, 1'b0, 2);
    `CHK("sr", 1'b1, self_refresh)
    `CHK("odt_sr", 1'b0, odt_on)
    `CHK("dll_sr", 2'h0, {dll_enabled, dll_locked})
    ctl.cmd(4'h7, 3'h0, 14'h0000, 1'b1, 2);
    `CHK("sr_x", 1'b0, self_refresh)
    `CHK("dll_x", 2'h2, {dll_enabled, dll_locked})
    ctl.term(1'b0);
    ck(210); // relock before any read
  endtask : t_odt_sr
  task t_qoff;
    read_drive = 1'b1;
    repeat (4) @(negedge clk_sys);
    `CHK("oe_rd", 1'b0, out_oe_n)
    emr(E1, 14'h1014);
    `CHK("oe_qoff", 1'b1, out_oe_n)
    read_drive = 1'b0;
    emr(E1, 14'h0014);
  endtask : t_qoff
  // each drive mode closed by calibration exit
  task t_drive;
    emr(E1, 14'h0094);
    `CHK("oe_d1", 1'b0, out_oe_n)
    `CHK("d1", 3'h6, {dq_level, dqs_level, dqs_n_level})
    emr(E1, 14'h0014);
    `CHK("oe_x", 1'b1, out_oe_n)
    emr(E1, 14'h0114);
    `CHK("d0", 3'h1, {dq_level, dqs_level, dqs_n_level})
    emr(E1, 14'h0014);
  endtask : t_drive
  // words wait in the buffer until adjust mode opens
  task t_adjust;
    logic [3:0] w [10];
    int du [10];
    int dd [10];
    w = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha, 4'h0, 4'h3};
    du = '{1, -1, 0, 0, 1, -1, 1, -1, 0, 0};
    dd = '{0, 0, 1, -1, 1, 1, -1, -1, 0, 0};
    push(4'h1);
    push(4'h1);
    `CHK("full", 1'b0, code_ready)
    code_valid = 1'b0;
    `CHK("held", 4'h8, pullup_step)
    emr(E1, 14'h0214); // additive latency kept
    `CHK("drain", 4'ha, pullup_step)
    up = 10;
    dn = 8;
    for (int i = 0; i < 10; i++) begin
      push(w[i]); // first beat in bit 3
      code_valid = 1'b0;
      repeat (4) @(negedge clk_sys);
      up += du[i];
      dn += dd[i];
      `CHK("up", 4'(up), pullup_step)
      `CHK("dn", 4'(dn), pulldown_step)
    end
    `CHK("rsv", 1, n_rsv)
    for (int i = 0; i < 10; i++) begin
      push(4'h1);
      push(4'h8);
    end
    code_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK("limits", 8'hf0, {pullup_step, pulldown_step})
    emr(E1, 14'h0014);
    emr(E1, 14'h0394);
    `CHK("dflt", 8'h88, {pullup_step, pulldown_step})
    emr(E1, 14'h0014);
  endtask : t_adjust
  // activate, posted column at latency 2, precharge-all
  task t_act;
    ctl.cmd(4'h3, 3'h5, 14'h2a5c, 1'b1, 0);
    ctl.cmd(4'h5, 3'h5, 14'h0010, 1'b1, 1); // read on the next clock
    r0 = n_rise;
    ck(4);
    `CHK("act", {3'h5, 14'h2a5c}, got_act)
    `CHK("col", 4'h5, got_col)
    `CHK("col_at", r0 + 2, col_rise)
    ctl.cmd(4'h4, 3'h5, 14'h0020, 1'b1, 4);
    `CHK("wr", 4'hd, got_col)
    for (int i = 0; i < 4; i++) ctl.cmd(4'h3, 3'(i), 14'h0001, 1'b1, 2);
    `CHK("open", 8'h2f, bank_open)
    ctl.cmd(4'h2, 3'h0, 14'h0400, 1'b1, 3);
    `CHK("closed", 8'h00, bank_open)
    ctl.cmd(4'h3, 3'h5, 14'h0003, 1'b1, 2);
    `CHK("reopen", 8'h20, bank_open)
    ctl.cmd(4'h2, 3'h0, 14'h0400, 1'b1, 3);
    emr(E1, 14'h0004); // zero latency: column goes inside at once
    ctl.cmd(4'h3, 3'h2, 14'h0007, 1'b1, 0);
    ctl.cmd(4'h4, 3'h2, 14'h0000, 1'b1, 1);
    r0 = n_rise;
    ck(2);
    `CHK("col_al0", r0, col_rise)
    `CHK("wr0", 4'ha, got_col)
  endtask : t_act
  // reset, then each scenario in turn
  initial begin
    nrst = 1'b0;
    read_drive = 1'b0;
    code_valid = 1'b0;
    code_word = 4'h0;
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    t_reset;
    t_init;
    t_odt_sr;
    t_qoff;
    t_drive;
    t_adjust;
    t_act;
    give_verdict;
  end
endmodule : dmo_top_test

// File: verilog/dmo_buf.sv
`timescale 1ns/1ps
module dmo_buf #(
  parameter int W = 4,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic nrst,
  dmo_stream_if.snk s,
  dmo_stream_if.src m
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [CW-1:0] cnt, next_cnt;
  logic push, pop;

  // honest flags: ready drops only when both entries hold words
  assign s.ready = (cnt != FULL);
  assign m.valid = (cnt != '0);
  assign m.data = mem[rp];
  assign push = s.valid && s.ready;
  assign pop = m.valid && m.ready;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  // pointer and fill level
  always_comb begin
    next_wp = push ? wrap_inc(wp) : wp;
    next_rp = pop ? wrap_inc(rp) : rp;
    next_cnt = cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // storage needs no reset, read is gated by valid
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp] <= s.data;
    end
  end
endmodule : dmo_buf

// File: verilog/dmo_pkg.sv
// Contract
// - dll switches off entering self-refresh, re-enabled and reset on exit
// - output-off bit 0 lets reads drive outputs; 1 keeps data and strobes off (code: reads only, calibration drive modes still drive)
// - calibration field 000 exit, 001 drive1, 010 drive0, 100 adjust, 111 default
// - code beats step pull-up, pull-down or both by one; others reserved
// - driver strength spans 16 steps, saturates at limits, shared by all lines
// - code beats taken first to last, never reordered by burst type
// - drive mode outputs on a fixed delay after enter and after exit
// - termination off in self-refresh, control pin ignored there
// - asserted termination pin connects termination at the nominal setting
// - activate: select and row strobe low, column strobe and write enable high
// - read or write accepted after activate, held additive latency 0 to 6
package dmo_pkg;
  // mode register selector on the bank bits
  localparam logic [1:0] SEL_MR = 2'h0;
  localparam logic [1:0] SEL_EMR1 = 2'h1;
  localparam logic [1:0] SEL_EMR2 = 2'h2;
  localparam logic [1:0] SEL_EMR3 = 2'h3;
  // field positions
  localparam int MR_DLL_RESET_POS = 8;
  localparam int MR_BL_LSB = 0;
  localparam logic [2:0] MR_BL4 = 3'h2;
  localparam int EMR1_DLL_OFF_POS = 0;
  localparam int EMR1_RTT0_POS = 2;
  localparam int EMR1_RTT1_POS = 6;
  localparam int EMR1_AL_LSB = 3;
  localparam int EMR1_OCD_LSB = 7;
  localparam int EMR1_QOFF_POS = 12;
  localparam int PRE_ALL_POS = 10;
  // calibration field codes
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] OCD_DRV1 = 3'h1;
  localparam logic [2:0] OCD_DRV0 = 3'h2;
  localparam logic [2:0] OCD_ADJ = 3'h4;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;
  // code word: first_code_beat in bit 3, last_code_beat in bit 0
  localparam int FIRST_CODE_BEAT_POS = 3;
  localparam int LAST_CODE_BEAT_POS = 0;
  localparam int CODE_W = 4;
  // timing
  localparam int CLK_PS = 5000;
  localparam int DLL_LOCK_CK = 200;
  localparam int OIT_NS = 12;
  localparam int OIT_CYC = (OIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int AL_MAX = 6;
  localparam int DRV_STEPS = 16;
  localparam logic [3:0] DRV_STEP_INIT = 4'h8;
  localparam logic [3:0] DRV_STEP_MAX = 4'(DRV_STEPS - 1);
  // calibration state
  typedef enum logic [3:0] {
    DMO_OCD_IDLE = 4'h1,
    DMO_OCD_DRV1 = 4'h2,
    DMO_OCD_DRV0 = 4'h4,
    DMO_OCD_ADJ = 4'h8
  } dmo_ocd_t;
endpackage : dmo_pkg

// File: verilog/dmo_stream_if.sv
`timescale 1ns/1ps
interface dmo_stream_if #(parameter int W = 4);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dmo_stream_if

// File: verilog/dmo_top.sv
`timescale 1ns/1ps
module dmo_top #(
  parameter int ROW_W = 14,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ck_pin,
  input wire logic cke_pin,
  input wire logic cs_n_pin,
  input wire logic ras_n_pin,
  input wire logic cas_n_pin,
  input wire logic we_n_pin,
  input wire logic [2:0] ba_pin,
  input wire logic [13:0] addr_pin,
  input wire logic odt_pin,
  input wire logic code_valid,
  input wire logic [3:0] code_word,
  output logic code_ready,
  input wire logic read_drive,
  output logic out_oe_n,
  output logic dq_level,
  output logic dqs_level,
  output logic dqs_n_level,
  output logic [3:0] pullup_step,
  output logic [3:0] pulldown_step,
  output logic code_reserved,
  output logic dll_enabled,
  output logic dll_locked,
  output logic self_refresh,
  output logic odt_on,
  output logic [1:0] rtt_sel,
  output logic [2:0] additive_latency,
  output logic burst_len4,
  output logic [13:0] emr2,
  output logic [13:0] emr3,
  output logic act_valid,
  output logic [2:0] act_bank,
  output logic [ROW_W-1:0] act_row,
  output logic col_valid,
  output logic col_write,
  output logic [2:0] col_bank,
  output logic [7:0] bank_open
);
  localparam int PW = 24;
  // idle pins: ck high so a clock already high at release is no rise, command deselected
  localparam logic [PW-1:0] PIN_IDLE = {1'b1, 1'b0, 4'hf, 1'b0, 3'h0, 14'h0000};
  localparam int OIT_A = dmo_pkg::OIT_CYC;
  localparam int AL_N = dmo_pkg::AL_MAX;

  // two-flop capture of every pin, ck included
  logic [PW-1:0] pin_s1, pin_s2;
  logic ck_s3;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      ck_s3 <= 1'b1;
    end else begin
      pin_s1 <= {ck_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, odt_pin, ba_pin, addr_pin};
      pin_s2 <= pin_s1;
      ck_s3 <= pin_s2[23];
    end
  end

  logic ck_rise, cke, cs_n, ras_n, cas_n, we_n, odt_s;
  logic [2:0] ba;
  logic [13:0] ad;
  // all pins share one sync depth so they stay aligned to the ck edge
  assign {cke, cs_n, ras_n, cas_n, we_n, odt_s, ba, ad} = pin_s2[22:0];
  assign ck_rise = pin_s2[23] && !ck_s3;

  logic cmd_on, c_mrs, c_act, c_pre, c_ref, c_rd, c_wr;
  assign cmd_on = ck_rise && !cs_n && !self_refresh;
  assign c_mrs = cmd_on && !ras_n && !cas_n && !we_n;
  assign c_act = cmd_on && !ras_n && cas_n && we_n;
  assign c_pre = cmd_on && !ras_n && cas_n && !we_n;
  assign c_ref = cmd_on && !ras_n && !cas_n && we_n;
  assign c_rd = cmd_on && ras_n && !cas_n && we_n;
  assign c_wr = cmd_on && ras_n && !cas_n && !we_n;
  // lock restarts must not be overtaken by the lock counter in the same cycle
  logic dll_rst, sr_enter;
  assign dll_rst = c_mrs && (ba[1:0] == dmo_pkg::SEL_MR) && ad[dmo_pkg::MR_DLL_RESET_POS];
  assign sr_enter = c_ref && !cke;

  // code beats pass through the two-entry buffer; drained only in adjust
  dmo_stream_if #(.W(dmo_pkg::CODE_W)) in_if ();
  dmo_stream_if #(.W(dmo_pkg::CODE_W)) out_if ();
  assign in_if.valid = code_valid;
  assign in_if.data = code_word;
  assign code_ready = in_if.ready;
  dmo_buf #(.W(dmo_pkg::CODE_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .s(in_if),
    .m(out_if)
  );

  function automatic logic [3:0] sat_step(input logic [3:0] v, input logic inc, input logic dec);
    if (inc && v != dmo_pkg::DRV_STEP_MAX) begin
      sat_step = v + 4'h1;
    end else if (dec && v != 4'h0) begin
      sat_step = v - 4'h1;
    end else begin
      sat_step = v;
    end
  endfunction : sat_step

  dmo_pkg::dmo_ocd_t ocd, next_ocd;
  logic dll_off, next_dll_off, qoff, next_qoff, next_self_refresh, drive_on, next_drive_on;
  logic [1:0] next_rtt_sel;
  logic [2:0] next_al, al_ce;
  logic next_burst_len4, next_code_reserved, next_act_valid, next_col_valid, next_col_write;
  logic next_dll_locked, drive_tgt, pop, bad;
  logic [7:0] lock_cnt, next_lock_cnt, next_bank_open;
  logic [3:0] oit_cnt, next_oit_cnt, next_pullup, next_pulldown, w;
  logic [13:0] next_emr2, next_emr3;
  logic [2:0] next_act_bank, next_col_bank;
  logic [ROW_W-1:0] next_act_row;
  logic [AL_N-1:0] pv, next_pv, pw, next_pw;
  logic [2:0] pb [AL_N];
  logic [2:0] next_pb [AL_N];

  assign drive_tgt = (ocd == dmo_pkg::DMO_OCD_DRV1) || (ocd == dmo_pkg::DMO_OCD_DRV0);
  assign pop = (ocd == dmo_pkg::DMO_OCD_ADJ) && out_if.valid;
  assign out_if.ready = (ocd == dmo_pkg::DMO_OCD_ADJ);
  assign w = out_if.data; // beat order fixed, burst type never consulted
  // both halves of a pair set at once is reserved
  assign bad = (w[0] && w[1]) || (w[2] && w[3]);
  assign al_ce = additive_latency;

  // next state of mode registers, calibration, dll, banks and column pipe
  always_comb begin
    next_ocd = ocd;
    next_dll_off = dll_off;
    next_qoff = qoff;
    next_rtt_sel = rtt_sel;
    next_al = additive_latency;
    next_burst_len4 = burst_len4;
    next_emr2 = emr2;
    next_emr3 = emr3;
    next_self_refresh = self_refresh;
    next_lock_cnt = lock_cnt;
    next_dll_locked = dll_locked;
    next_pullup = pullup_step;
    next_pulldown = pulldown_step;
    next_code_reserved = 1'b0;
    next_oit_cnt = oit_cnt;
    next_drive_on = drive_on;
    next_bank_open = bank_open;
    next_act_valid = 1'b0;
    next_act_bank = act_bank;
    next_act_row = act_row;
    next_col_valid = 1'b0;
    next_col_write = col_write;
    next_col_bank = col_bank;
    next_pv = pv;
    next_pw = pw;
    next_pb = pb;
    if (c_mrs) begin
      unique case (ba[1:0])
        dmo_pkg::SEL_MR: begin
          next_burst_len4 = (ad[dmo_pkg::MR_BL_LSB +: 3] == dmo_pkg::MR_BL4);
          if (ad[dmo_pkg::MR_DLL_RESET_POS]) begin
            next_lock_cnt = '0; // relock window starts
            next_dll_locked = 1'b0;
          end
        end
        dmo_pkg::SEL_EMR1: begin
          next_dll_off = ad[dmo_pkg::EMR1_DLL_OFF_POS];
          next_qoff = ad[dmo_pkg::EMR1_QOFF_POS];
          next_rtt_sel = {ad[dmo_pkg::EMR1_RTT1_POS], ad[dmo_pkg::EMR1_RTT0_POS]};
          next_al = ad[dmo_pkg::EMR1_AL_LSB +: 3];
          // calibration field decode
          unique case (ad[dmo_pkg::EMR1_OCD_LSB +: 3])
            dmo_pkg::OCD_DRV1: next_ocd = dmo_pkg::DMO_OCD_DRV1;
            dmo_pkg::OCD_DRV0: next_ocd = dmo_pkg::DMO_OCD_DRV0;
            dmo_pkg::OCD_ADJ: next_ocd = dmo_pkg::DMO_OCD_ADJ;
            dmo_pkg::OCD_DEFAULT: begin
              next_ocd = dmo_pkg::DMO_OCD_IDLE;
              next_pullup = dmo_pkg::DRV_STEP_INIT;
              next_pulldown = dmo_pkg::DRV_STEP_INIT;
            end
            default: next_ocd = dmo_pkg::DMO_OCD_IDLE; // exit; reserved codes treated alike
          endcase
        end
        dmo_pkg::SEL_EMR2: next_emr2 = ad;
        dmo_pkg::SEL_EMR3: next_emr3 = ad;
      endcase
    end
    // self-refresh: refresh with cke low enters, cke high at an edge exits
    if (sr_enter) begin
      next_self_refresh = 1'b1;
      next_lock_cnt = '0; // dll switched off on entry
      next_dll_locked = 1'b0;
    end else if (self_refresh && ck_rise && cke) begin
      next_self_refresh = 1'b0;
      next_lock_cnt = '0; // dll reset on exit
      next_dll_locked = 1'b0;
    end
    if (ck_rise && dll_enabled && !dll_locked && !dll_rst && !sr_enter) begin
      next_lock_cnt = lock_cnt + 8'h1;
      next_dll_locked = (lock_cnt == 8'(dmo_pkg::DLL_LOCK_CK - 1));
    end
    // one shared setting for all lines, saturating at the ends
    if (pop) begin
      if (bad) begin
        next_code_reserved = 1'b1;
      end else begin
        next_pullup = sat_step(pullup_step, w[0], w[1]);
        next_pulldown = sat_step(pulldown_step, w[2], w[3]);
      end
    end
    // outputs follow the drive state one fixed delay later
    if (drive_tgt != drive_on) begin
      if (oit_cnt == 4'h0) begin
        next_oit_cnt = 4'(OIT_A - 1);
      end else if (oit_cnt == 4'h1) begin
        next_drive_on = drive_tgt;
        next_oit_cnt = 4'h0;
      end else begin
        next_oit_cnt = oit_cnt - 4'h1;
      end
      if (OIT_A == 1) begin
        next_drive_on = drive_tgt;
      end
    end else begin
      next_oit_cnt = 4'h0;
    end
    if (c_act) begin
      next_bank_open[ba] = 1'b1;
      next_act_valid = 1'b1;
      next_act_bank = ba;
      next_act_row = ad[ROW_W-1:0];
    end
    if (c_pre) begin
      if (ad[dmo_pkg::PRE_ALL_POS]) begin
        next_bank_open = '0;
      end else begin
        next_bank_open[ba] = 1'b0;
      end
    end
    // column commands wait additive latency ck edges before going inside
    if (ck_rise) begin
      for (int i = 0; i < AL_N; i++) begin
        next_pv[i] = (i + 1 < AL_N) ? pv[(i + 1) % AL_N] : 1'b0;
        next_pw[i] = (i + 1 < AL_N) ? pw[(i + 1) % AL_N] : 1'b0;
        next_pb[i] = (i + 1 < AL_N) ? pb[(i + 1) % AL_N] : 3'h0;
      end
      if ((c_rd || c_wr) && al_ce == 3'h0) begin
        next_col_valid = 1'b1;
        next_col_write = c_wr;
        next_col_bank = ba;
      end else if (pv[0]) begin
        next_col_valid = 1'b1;
        next_col_write = pw[0];
        next_col_bank = pb[0];
      end
      if ((c_rd || c_wr) && al_ce != 3'h0 && al_ce <= 3'(AL_N)) begin
        next_pv[al_ce - 3'h1] = 1'b1;
        next_pw[al_ce - 3'h1] = c_wr;
        next_pb[al_ce - 3'h1] = ba;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ocd <= dmo_pkg::DMO_OCD_IDLE;
      dll_off <= 1'b0;
      qoff <= 1'b0;
      rtt_sel <= 2'h0;
      additive_latency <= 3'h0;
      burst_len4 <= 1'b0;
      emr2 <= 14'h0000;
      emr3 <= 14'h0000;
      self_refresh <= 1'b0;
      lock_cnt <= 8'h00;
      dll_locked <= 1'b0;
      pullup_step <= dmo_pkg::DRV_STEP_INIT;
      pulldown_step <= dmo_pkg::DRV_STEP_INIT;
      code_reserved <= 1'b0;
      oit_cnt <= 4'h0;
      drive_on <= 1'b0;
      bank_open <= 8'h00;
      act_valid <= 1'b0;
      act_bank <= 3'h0;
      act_row <= '0;
      col_valid <= 1'b0;
      col_write <= 1'b0;
      col_bank <= 3'h0;
      pv <= '0;
      pw <= '0;
      for (int i = 0; i < AL_N; i++) begin
        pb[i] <= 3'h0;
      end
    end else begin
      ocd <= next_ocd;
      dll_off <= next_dll_off;
      qoff <= next_qoff;
      rtt_sel <= next_rtt_sel;
      additive_latency <= next_al;
      burst_len4 <= next_burst_len4;
      emr2 <= next_emr2;
      emr3 <= next_emr3;
      self_refresh <= next_self_refresh;
      lock_cnt <= next_lock_cnt;
      dll_locked <= next_dll_locked;
      pullup_step <= next_pullup;
      pulldown_step <= next_pulldown;
      code_reserved <= next_code_reserved;
      oit_cnt <= next_oit_cnt;
      drive_on <= next_drive_on;
      bank_open <= next_bank_open;
      act_valid <= next_act_valid;
      act_bank <= next_act_bank;
      act_row <= next_act_row;
      col_valid <= next_col_valid;
      col_write <= next_col_write;
      col_bank <= next_col_bank;
      pv <= next_pv;
      pw <= next_pw;
      pb <= next_pb;
    end
  end

  // output levels and termination; qoff masks reads but not calibration drive
  logic next_odt_on, next_oe_n, next_dq;
  always_comb begin
    next_oe_n = !((read_drive && !qoff) || drive_on);
    next_dq = (ocd == dmo_pkg::DMO_OCD_DRV1);
    next_odt_on = odt_s && !self_refresh && (rtt_sel != 2'h0);
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      out_oe_n <= 1'b1;
      dq_level <= 1'b0;
      odt_on <= 1'b0;
    end else begin
      out_oe_n <= next_oe_n;
      dq_level <= next_dq;
      odt_on <= next_odt_on;
    end
  end
  assign dqs_level = dq_level;
  assign dqs_n_level = !dq_level;
  assign dll_enabled = !dll_off && !self_refresh;

  property p_qoff;
    @(posedge clk_sys) disable iff (!nrst) (qoff && !drive_on) |=> (out_oe_n || drive_on);
  endproperty
  a_qoff: assert property (p_qoff) else $error("outputs driven with output-off set");

  property p_drive_delay;
    @(posedge clk_sys) disable iff (!nrst) ($rose(drive_tgt) && !drive_on) |-> ##OIT_A (drive_on || !drive_tgt);
  endproperty
  a_drive_delay: assert property (p_drive_delay) else $error("drive mode outputs late");

  property p_drive_early;
    @(posedge clk_sys) disable iff (!nrst) $rose(drive_tgt) |=> !drive_on;
  endproperty
  a_drive_early: assert property (p_drive_early) else $error("drive mode outputs early");

  property p_step_sat;
    @(posedge clk_sys) disable iff (!nrst)
      (pop && !bad && w[0] && pullup_step == dmo_pkg::DRV_STEP_MAX) |=> pullup_step == dmo_pkg::DRV_STEP_MAX;
  endproperty
  a_step_sat: assert property (p_step_sat) else $error("pull-up step wrapped");

  property p_step_inc;
    @(posedge clk_sys) disable iff (!nrst)
      (pop && w == 4'h4 && pulldown_step != dmo_pkg::DRV_STEP_MAX) |=> pulldown_step == $past(pulldown_step) + 4'h1;
  endproperty
  a_step_inc: assert property (p_step_inc) else $error("pull-down did not step up");

  property p_odt_sr;
    @(posedge clk_sys) disable iff (!nrst) self_refresh ##1 self_refresh |-> !odt_on;
  endproperty
  a_odt_sr: assert property (p_odt_sr) else $error("termination on in self-refresh");

  property p_odt_on;
    @(posedge clk_sys) disable iff (!nrst) (odt_s && !self_refresh && rtt_sel != 2'h0) |=> odt_on;
  endproperty
  a_odt_on: assert property (p_odt_on) else $error("termination not connected");

  property p_dll_sr;
    @(posedge clk_sys) disable iff (!nrst) self_refresh |-> (!dll_enabled && !dll_locked);
  endproperty
  a_dll_sr: assert property (p_dll_sr) else $error("dll active in self-refresh");

  property p_al0;
    @(posedge clk_sys) disable iff (!nrst) ((c_rd || c_wr) && additive_latency == 3'h0) |=> col_valid && col_bank == $past(ba);
  endproperty
  a_al0: assert property (p_al0) else $error("column command not issued at zero latency");

  property p_act;
    @(posedge clk_sys) disable iff (!nrst) c_act |=> act_valid && bank_open[act_bank] && act_bank == $past(ba);
  endproperty
  a_act: assert property (p_act) else $error("activate not recorded");

  property p_exit;
    @(posedge clk_sys) disable iff (!nrst)
      (c_mrs && ba[1:0] == dmo_pkg::SEL_EMR1 && ad[9:7] == dmo_pkg::OCD_EXIT) |=> ocd == dmo_pkg::DMO_OCD_IDLE && !out_if.ready;
  endproperty
  a_exit: assert property (p_exit) else $error("calibration exit not taken");
endmodule : dmo_top
